/* File: hw/lmr_pkg.sv */
// Shared constants and types for the line monitor readout registers
package lmr_pkg;

  // Register port geometry: byte address, word per register index
  localparam int REG_ADDR_W = 9;
  localparam int REG_DATA_W = 8;
  localparam int IDX_W = 7;
  localparam logic [IDX_W-1:0] IDX_NONE = 7'h7f;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_POWER_MONITOR_SELECT = 7'h4c;
  localparam logic [IDX_W-1:0] IDX_TRANSISTOR_POWER_READING = 7'h4d;
  localparam logic [IDX_W-1:0] IDX_LOOP_VOLTAGE_READING = 7'h4e;
  localparam logic [IDX_W-1:0] IDX_LOOP_CURRENT_READING = 7'h4f;
  localparam logic [IDX_W-1:0] IDX_TIP_VOLTAGE_READING = 7'h50;
  localparam logic [IDX_W-1:0] IDX_RING_VOLTAGE_READING = 7'h51;

  // Reset values
  localparam logic [7:0] RST_POWER_MONITOR_SELECT = 8'h00;
  localparam logic [7:0] RST_TRANSISTOR_POWER_READING = 8'h00;
  localparam logic [7:0] RST_LOOP_VOLTAGE_READING = 8'h00;
  localparam logic [7:0] RST_LOOP_CURRENT_READING = 8'h00;
  localparam logic [7:0] RST_TIP_VOLTAGE_READING = 8'h00;
  localparam logic [7:0] RST_RING_VOLTAGE_READING = 8'h00;

  // Field layout
  localparam int SEL_W = 3;
  localparam int SIGN_BIT = 6;
  localparam int MAG_W = 6;

  // Selector codes, transistors one to six
  localparam logic [SEL_W-1:0] SEL_Q1 = 3'h0;
  localparam logic [SEL_W-1:0] SEL_Q2 = 3'h1;
  localparam logic [SEL_W-1:0] SEL_Q3 = 3'h2;
  localparam logic [SEL_W-1:0] SEL_Q4 = 3'h3;
  localparam logic [SEL_W-1:0] SEL_Q5 = 3'h4;
  localparam logic [SEL_W-1:0] SEL_Q6 = 3'h5;
  localparam int NUM_TRANSISTORS = 6;

  // Conversion steps in front-end units (power 10 uW, voltage mV, current uA)
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] PWR_STEP_HIGH = 16'h0be0;
  localparam logic [DIV_W-1:0] PWR_STEP_LOW = 16'h016a;
  localparam logic [DIV_W-1:0] LOOP_V_STEP = 16'h05dc;
  localparam logic [DIV_W-1:0] LOOP_I_STEP = 16'h04f6;
  localparam logic [DIV_W-1:0] LINE_V_STEP = 16'h0178;

  // Code ceilings
  localparam logic [7:0] CODE8_MAX = 8'hff;
  localparam logic [7:0] MAG6_MAX = 8'h3f;

  // Front-end raw width must hold full-scale power, 780000 x 10 uW
  localparam int RAW_W_MIN = 20;
  localparam int RAW_W_MAX = 32;

  typedef enum logic [2:0] {
    CH_POWER, CH_LOOP_V, CH_LOOP_I, CH_TIP, CH_RING
  } lmr_chan_t;

  typedef enum logic [0:0] {
    ST_ISSUE, ST_WAIT
  } lmr_seq_state_t;

endpackage

/* File: hw/lmr_div_if.sv */
// Request and answer signals between the sequencer and the divider
`timescale 1ns/1ps
interface lmr_div_if #(parameter int DW = 20);
  logic start;
  logic [DW-1:0] dividend;
  logic [15:0] divisor;
  logic [7:0] limit;
  logic done;
  logic [7:0] quotient;

  modport client (output start, output dividend, output divisor, output limit,
    input done, input quotient);
  modport server (input start, input dividend, input divisor, input limit,
    output done, output quotient);
endinterface

/* File: hw/lmr_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
module lmr_sync
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic d,
  output logic q
);
  logic meta;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      meta <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* File: hw/lmr_div.sv */
// Serial restoring divider with a saturating quotient
`timescale 1ns/1ps
module lmr_div
  import lmr_pkg::*;
#(
  parameter int DW = 20
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  lmr_div_if.server dv
);
  logic busy, next_busy;
  logic done, next_done;
  logic [5:0] cnt, next_cnt;
  logic [15:0] rem, next_rem;
  logic [15:0] dvs, next_dvs;
  logic [7:0] lim, next_lim;
  logic [7:0] qout, next_qout;
  logic [DW-1:0] quo, next_quo;
  logic [16:0] shifted;
  logic fits;

  if (DW < 8 || DW > 32)
  begin : g_chk
    $error("lmr_div: DW must be 8 to 32");
  end

  function automatic logic [7:0] saturate(input logic [DW-1:0] q, input logic [7:0] l);
    if (q > DW'(l))
      return l;
    return q[7:0];
  endfunction

  always_comb
  begin
    next_busy = busy;
    next_done = 1'b0;
    next_cnt = cnt;
    next_rem = rem;
    next_dvs = dvs;
    next_lim = lim;
    next_qout = qout;
    next_quo = quo;
    shifted = {rem, quo[DW-1]};
    fits = (shifted >= {1'b0, dvs});
    if (busy)
    begin
      next_rem = fits ? 16'(shifted - {1'b0, dvs}) : shifted[15:0];
      next_quo = {quo[DW-2:0], fits};
      next_cnt = 6'(cnt - 6'h01);
      if (cnt == 6'h01)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_qout = saturate(next_quo, lim);
      end
    end
    else if (dv.start)
    begin
      // Zero divisor gives all ones, which saturates to the limit
      next_busy = 1'b1;
      next_cnt = 6'(DW);
      next_rem = 16'h0000;
      next_quo = dv.dividend;
      next_dvs = dv.divisor;
      next_lim = dv.limit;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= 6'h00;
      rem <= 16'h0000;
      dvs <= 16'h0000;
      lim <= 8'h00;
      qout <= 8'h00;
      quo <= '0;
    end
    else
    begin
      busy <= next_busy;
      done <= next_done;
      cnt <= next_cnt;
      rem <= next_rem;
      dvs <= next_dvs;
      lim <= next_lim;
      qout <= next_qout;
      quo <= next_quo;
    end
  end

  assign dv.done = done;
  assign dv.quotient = qout;
endmodule

/* File: hw/lmr_top.sv */
// Line monitor readout registers: selector, power, loop and line voltage readings
//
// Summary of operation
// - Three-bit selector, codes 0 to 5 pick transistors one to six; 6, 7 undefined.
// - Power register shows real-time power of the currently selected transistor.
// - Transistors 1, 2, 5, 6: 0x00 to 0xff covers 0 to 7.8 W, 30.4 mW steps.
// - Transistors 3, 4: 0x00 to 0xff covers 0 to 0.9 W, 3.62 mW steps.
// - Loop voltage bit 6: 0 when tip above ring, 1 when ring above tip.
// - Loop voltage bits 5:0: magnitude 0 to 94.5 V, 1.5 V steps.
// - Loop current bit 6: 0 forward current, 1 reverse current.
// - Loop current bits 5:0: magnitude 0 to 80 mA, 1.27 mA steps.
// - Tip to ground as 8-bit code, 0 V up to -95.88 V, 0.376 V steps.
// - Ring to ground with the same scale as the tip reading.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module lmr_top
  import lmr_pkg::*;
#(
  parameter int RAW_W = 20
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DATA_W-1:0] reg_rdata,
  input wire logic fe_strobe,
  input wire logic [NUM_TRANSISTORS-1:0][RAW_W-1:0] fe_power,
  input wire logic [RAW_W-1:0] fe_loop_v_mag,
  input wire logic fe_loop_v_neg,
  input wire logic [RAW_W-1:0] fe_loop_i_mag,
  input wire logic fe_loop_i_rev,
  input wire logic [RAW_W-1:0] fe_tip_mag,
  input wire logic [RAW_W-1:0] fe_ring_mag
);
  if (RAW_W < RAW_W_MIN || RAW_W > RAW_W_MAX)
  begin : g_chk
    $error("lmr_top: RAW_W out of range");
  end

  // Register file
  logic [SEL_W-1:0] power_monitor_select, next_power_monitor_select;
  logic [7:0] transistor_power_reading, next_transistor_power_reading;
  logic [7:0] loop_voltage_reading, next_loop_voltage_reading;
  logic [7:0] loop_current_reading, next_loop_current_reading;
  logic [7:0] tip_voltage_reading, next_tip_voltage_reading;
  logic [7:0] ring_voltage_reading, next_ring_voltage_reading;
  logic [REG_DATA_W-1:0] next_reg_rdata;

  // Input staging: one stage every cycle, snapshot on the strobe edge
  logic [NUM_TRANSISTORS-1:0][RAW_W-1:0] stg_power, snap_power;
  logic [RAW_W-1:0] stg_loop_v, snap_loop_v;
  logic [RAW_W-1:0] stg_loop_i, snap_loop_i;
  logic [RAW_W-1:0] stg_tip, snap_tip;
  logic [RAW_W-1:0] stg_ring, snap_ring;
  logic stg_v_neg, snap_v_neg;
  logic stg_i_rev, snap_i_rev;
  logic strobe_sync, strobe_d;
  logic take_snapshot;

  // Conversion sequencer
  lmr_seq_state_t state, next_state;
  lmr_chan_t chan, next_chan;
  logic op_sign, next_op_sign;

  lmr_div_if #(.DW(RAW_W)) div_bus ();

  lmr_sync lmr_sync_inst
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .d(fe_strobe),
    .q(strobe_sync)
  );

  lmr_div #(.DW(RAW_W)) lmr_div_inst
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .dv(div_bus)
  );

  // Misaligned or out-of-map addresses decode to no register
  function automatic logic [IDX_W-1:0] reg_index(input logic [REG_ADDR_W-1:0] a);
    if (a[1:0] != 2'h0)
      return IDX_NONE;
    return a[REG_ADDR_W-1:2];
  endfunction

  function automatic logic [DIV_W-1:0] power_step(input logic [SEL_W-1:0] s);
    return (s == SEL_Q3 || s == SEL_Q4) ? PWR_STEP_LOW : PWR_STEP_HIGH;
  endfunction

  assign take_snapshot = strobe_sync & ~strobe_d;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      stg_power <= '0;
      stg_loop_v <= '0;
      stg_loop_i <= '0;
      stg_tip <= '0;
      stg_ring <= '0;
      stg_v_neg <= 1'b0;
      stg_i_rev <= 1'b0;
      snap_power <= '0;
      snap_loop_v <= '0;
      snap_loop_i <= '0;
      snap_tip <= '0;
      snap_ring <= '0;
      snap_v_neg <= 1'b0;
      snap_i_rev <= 1'b0;
      strobe_d <= 1'b0;
    end
    else
    begin
      stg_power <= fe_power;
      stg_loop_v <= fe_loop_v_mag;
      stg_loop_i <= fe_loop_i_mag;
      stg_tip <= fe_tip_mag;
      stg_ring <= fe_ring_mag;
      stg_v_neg <= fe_loop_v_neg;
      stg_i_rev <= fe_loop_i_rev;
      strobe_d <= strobe_sync;
      // Data held stable while the strobe is high, so the late snapshot is safe
      if (take_snapshot)
      begin
        snap_power <= stg_power;
        snap_loop_v <= stg_loop_v;
        snap_loop_i <= stg_loop_i;
        snap_tip <= stg_tip;
        snap_ring <= stg_ring;
        snap_v_neg <= stg_v_neg;
        snap_i_rev <= stg_i_rev;
      end
    end
  end

  // Operands for the channel being issued
  always_comb
  begin
    div_bus.start = (state == ST_ISSUE);
    div_bus.dividend = '0;
    div_bus.divisor = LINE_V_STEP;
    div_bus.limit = CODE8_MAX;
    unique case (chan)
      CH_POWER:
      begin
        // selected transistor; undefined codes read as zero power
        if (power_monitor_select <= SEL_Q6)
          div_bus.dividend = snap_power[power_monitor_select];
        div_bus.divisor = power_step(power_monitor_select);
      end
      CH_LOOP_V:
      begin
        div_bus.dividend = snap_loop_v;
        div_bus.divisor = LOOP_V_STEP;
        div_bus.limit = MAG6_MAX;
      end
      CH_LOOP_I:
      begin
        div_bus.dividend = snap_loop_i;
        div_bus.divisor = LOOP_I_STEP;
        div_bus.limit = MAG6_MAX;
      end
      CH_TIP:
      begin
        div_bus.dividend = snap_tip;
      end
      CH_RING:
      begin
        div_bus.dividend = snap_ring;
      end
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_chan = chan;
    next_op_sign = op_sign;
    unique case (state)
      ST_ISSUE:
      begin
        next_state = ST_WAIT;
        next_op_sign = (chan == CH_LOOP_I) ? snap_i_rev : snap_v_neg;
      end
      ST_WAIT:
      begin
        if (div_bus.done)
        begin
          next_state = ST_ISSUE;
          unique case (chan)
            CH_POWER: next_chan = CH_LOOP_V;
            CH_LOOP_V: next_chan = CH_LOOP_I;
            CH_LOOP_I: next_chan = CH_TIP;
            CH_TIP: next_chan = CH_RING;
            CH_RING: next_chan = CH_POWER;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state <= ST_ISSUE;
      chan <= CH_POWER;
      op_sign <= 1'b0;
    end
    else
    begin
      state <= next_state;
      chan <= next_chan;
      op_sign <= next_op_sign;
    end
  end

  // Register updates and the read port
  always_comb
  begin
    next_power_monitor_select = power_monitor_select;
    next_transistor_power_reading = transistor_power_reading;
    next_loop_voltage_reading = loop_voltage_reading;
    next_loop_current_reading = loop_current_reading;
    next_tip_voltage_reading = tip_voltage_reading;
    next_ring_voltage_reading = ring_voltage_reading;
    next_reg_rdata = '0;
    // selector write keeps bits 2:0 only
    if (reg_wr && reg_index(reg_addr) == IDX_POWER_MONITOR_SELECT)
      next_power_monitor_select = reg_wdata[SEL_W-1:0];
    if (state == ST_WAIT && div_bus.done)
    begin
      unique case (chan)
        CH_POWER: next_transistor_power_reading = div_bus.quotient;
        CH_LOOP_V:
        begin
          next_loop_voltage_reading = 8'h00;
          next_loop_voltage_reading[SIGN_BIT] = op_sign;
          next_loop_voltage_reading[MAG_W-1:0] = div_bus.quotient[MAG_W-1:0];
        end
        CH_LOOP_I:
        begin
          next_loop_current_reading = 8'h00;
          next_loop_current_reading[SIGN_BIT] = op_sign;
          next_loop_current_reading[MAG_W-1:0] = div_bus.quotient[MAG_W-1:0];
        end
        CH_TIP: next_tip_voltage_reading = div_bus.quotient;
        CH_RING: next_ring_voltage_reading = div_bus.quotient;
      endcase
    end
    if (reg_rd)
    begin
      // unused bits and unmapped addresses read zero
      unique case (reg_index(reg_addr))
        IDX_POWER_MONITOR_SELECT: next_reg_rdata = 8'(power_monitor_select);
        IDX_TRANSISTOR_POWER_READING: next_reg_rdata = transistor_power_reading;
        IDX_LOOP_VOLTAGE_READING: next_reg_rdata = loop_voltage_reading;
        IDX_LOOP_CURRENT_READING: next_reg_rdata = loop_current_reading;
        IDX_TIP_VOLTAGE_READING: next_reg_rdata = tip_voltage_reading;
        IDX_RING_VOLTAGE_READING: next_reg_rdata = ring_voltage_reading;
        default: next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      power_monitor_select <= RST_POWER_MONITOR_SELECT[SEL_W-1:0];
      transistor_power_reading <= RST_TRANSISTOR_POWER_READING;
      loop_voltage_reading <= RST_LOOP_VOLTAGE_READING;
      loop_current_reading <= RST_LOOP_CURRENT_READING;
      tip_voltage_reading <= RST_TIP_VOLTAGE_READING;
      ring_voltage_reading <= RST_RING_VOLTAGE_READING;
      reg_rdata <= '0;
    end
    else
    begin
      power_monitor_select <= next_power_monitor_select;
      transistor_power_reading <= next_transistor_power_reading;
      loop_voltage_reading <= next_loop_voltage_reading;
      loop_current_reading <= next_loop_current_reading;
      tip_voltage_reading <= next_tip_voltage_reading;
      ring_voltage_reading <= next_ring_voltage_reading;
      reg_rdata <= next_reg_rdata;
    end
  end
endmodule

/* File: sim/lmr_top_sva.sv */
// Port-level assertions for the line monitor readout registers
`timescale 1ns/1ps
module lmr_top_sva
  import lmr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [REG_DATA_W-1:0] reg_rdata
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_reset_reads_zero: assert property ($past(sys_rst) |-> reg_rdata == 8'h00)
    else $error("read data not zero after reset");
  // Read data is a one-cycle answer, quiet otherwise
  a_idle_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_sel_readback: assert property ((reg_wr && reg_addr == 9'h130) ##1
    (reg_rd && reg_addr == 9'h130) |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
    else $error("selector read back differs from write");
  a_sel_ro_write: assert property ((reg_wr && reg_addr == 9'h130) ##1
    (reg_wr && reg_addr == 9'h134) ##1 (reg_rd && reg_addr == 9'h130)
    |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3))
    else $error("read-only write disturbed the selector");
  a_sel_upper_zero: assert property ($past(reg_rd) && $past(reg_addr) == 9'h130
    |-> reg_rdata[7:3] == 5'h00)
    else $error("selector unused bits not zero");
  a_loop_top_zero: assert property ($past(reg_rd) &&
    ($past(reg_addr) == 9'h138 || $past(reg_addr) == 9'h13c) |-> !reg_rdata[7])
    else $error("loop reading bit 7 not zero");
  a_misalign_zero: assert property ($past(reg_rd) && $past(reg_addr[1:0]) != 2'h0
    |-> reg_rdata == 8'h00)
    else $error("misaligned read not zero");
  a_unmapped_zero: assert property ($past(reg_rd) &&
    ($past(reg_addr[8:2]) < 7'h4c || $past(reg_addr[8:2]) > 7'h51) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind lmr_top lmr_top_sva lmr_top_sva_inst (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata)
);

/* File: sim/test_line_monitor_readout_regs.sv */
// Self-checking bench for the line monitor readout registers
`timescale 1ns/1ps
module test_line_monitor_readout_regs
  import lmr_pkg::*;
();
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [8:0] reg_addr = 9'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic fe_strobe = 1'b0;
  logic [5:0][19:0] pw = '0;
  logic [19:0] lv = '0;
  logic [19:0] li = '0;
  logic [19:0] tv = '0;
  logic [19:0] rv = '0;
  logic lvn = 1'b0;
  logic lir = 1'b0;
  logic [7:0] v;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  lmr_top #(.RAW_W(20)) lmr_top_inst (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .fe_strobe(fe_strobe),
    .fe_power(pw),
    .fe_loop_v_mag(lv),
    .fe_loop_v_neg(lvn),
    .fe_loop_i_mag(li),
    .fe_loop_i_rev(lir),
    .fe_tip_mag(tv),
    .fe_ring_mag(rv)
  );

  always #50 sys_clk = ~sys_clk;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, a run needs about 4300 cycles
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] code(input logic [19:0] raw, input logic [15:0] step,
                                      input int lim);
    int q;
    q = int'(raw) / int'(step);
    code = (q > lim) ? lim[7:0] : q[7:0];
  endfunction

  // The write strobe stays high until the next access, so back-to-back cycles need no gap
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask

  // Boundary raw values: exact steps, one below, and saturation
  task automatic load(input int k);
    idle(1);
    pw[0] <= (k == 0) ? 20'd15200 : 20'd776000;
    pw[1] <= (k == 0) ? 20'd30399 : 20'd3039;
    pw[2] <= (k == 0) ? 20'd2534 : 20'd92309;
    pw[3] <= (k == 0) ? 20'd92671 : 20'd0;
    pw[4] <= (k == 0) ? 20'd780000 : 20'd191520;
    pw[5] <= (k == 0) ? 20'd0 : 20'd100000;
    lv <= (k == 0) ? 20'd94500 : 20'd30000;
    lvn <= (k == 0);
    li <= (k == 0) ? 20'd1269 : 20'd80000;
    lir <= (k != 0);
    tv <= (k == 0) ? 20'd95880 : 20'd0;
    rv <= (k == 0) ? 20'd37600 : 20'd1000000;
    @(posedge sys_clk);
    fe_strobe <= 1'b1;
    repeat (3) @(posedge sys_clk);
    fe_strobe <= 1'b0;
    repeat (250) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    int i;
    for (i = 0; i < 6; i++)
    begin
      rd(9'h130 + 9'(i * 4), v);
      check(v, 8'h00);
    end
    rd(9'h131, v);
    check(v, 8'h00);
    rd(9'h1fc, v);
    check(v, 8'h00);
  endtask

  task automatic t_select();
    int c;
    for (c = 0; c < 8; c++)
    begin
      wr(9'h130, 8'hf8 | c[7:0]);
      rd(9'h130, v);
      check(v, c[7:0]);
    end
    wr(9'h130, 8'h05);
    wr(9'h134, 8'haa);
    rd(9'h130, v);
    check(v, 8'h05);
  endtask

  task automatic t_readings();
    int s;
    logic [7:0] e;
    for (s = 0; s < 8; s++)
    begin
      wr(9'h130, s[7:0]);
      idle(150);
      rd(9'h134, v);
      e = (s > 5) ? 8'h00 : code(pw[s], (s == 2 || s == 3) ? PWR_STEP_LOW : PWR_STEP_HIGH, 255);
      check(v, e);
    end
    rd(9'h138, v);
    e = code(lv, LOOP_V_STEP, 63);
    check(v, {1'b0, lvn, e[5:0]});
    rd(9'h13c, v);
    e = code(li, LOOP_I_STEP, 63);
    check(v, {1'b0, lir, e[5:0]});
    rd(9'h140, v);
    check(v, code(tv, LINE_V_STEP, 255));
    rd(9'h144, v);
    check(v, code(rv, LINE_V_STEP, 255));
  endtask

  // Read straight after each write, before a refresh could hide a landed write
  task automatic t_ro_writes();
    logic [7:0] e;
    // Selector left at 7 by the sweep, so power reads zero
    wr(9'h134, 8'h5a);
    rd(9'h134, v);
    check(v, 8'h00);
    wr(9'h138, 8'h5a);
    rd(9'h138, v);
    e = code(lv, LOOP_V_STEP, 63);
    check(v, {1'b0, lvn, e[5:0]});
    wr(9'h13c, 8'h5a);
    rd(9'h13c, v);
    e = code(li, LOOP_I_STEP, 63);
    check(v, {1'b0, lir, e[5:0]});
    wr(9'h140, 8'h5a);
    rd(9'h140, v);
    check(v, code(tv, LINE_V_STEP, 255));
    wr(9'h144, 8'h5a);
    rd(9'h144, v);
    check(v, code(rv, LINE_V_STEP, 255));
    idle(1);
    t_readings();
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_select();
    load(0);
    t_readings();
    t_ro_writes();
    load(1);
    t_readings();
    // Mid-run reset clears the selector and every reading
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    test_done();
  end
endmodule
